// [shared/secp_pkg.sv]
/*
 constants and types for the serial eeprom command port.
 assumes a single 40 MHz clock and serial pins sampled synchronously.
*/
package secp_pkg;

    // clock rate and self-timed cycle limits
    localparam int CLK_MHZ = 40;
    localparam int WRITE8_TIME_US = 1000;
    localparam int WRITE16_TIME_US = 2000;
    localparam int ALL_TIME_US = 15000;
    localparam int WRITE8_CYCLES = WRITE8_TIME_US * CLK_MHZ;
    localparam int WRITE16_CYCLES = WRITE16_TIME_US * CLK_MHZ;
    localparam int ALL_CYCLES = ALL_TIME_US * CLK_MHZ;

    // array shape
    localparam int MEM_BYTES = 128;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;

    // frame field lengths, counted in clock edges after the start bit
    localparam logic [4:0] OP_BITS = 5'h04;
    localparam logic [4:0] HDR16_BITS = 5'h0A;
    localparam logic [4:0] HDR8_BITS = 5'h0B;
    localparam logic [4:0] DATA16_BITS = 5'h10;
    localparam logic [4:0] DATA8_BITS = 5'h08;

    // opcodes
    localparam logic [1:0] READ_PFX = 2'h2;
    localparam logic [3:0] OP_ENABLE = 4'h3;
    localparam logic [3:0] OP_DISABLE = 4'h0;
    localparam logic [3:0] OP_ERASE_ALL = 4'h2;
    localparam logic [3:0] OP_WRITE_ALL = 4'h1;

    typedef logic [19:0] secp_timer_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SHIFT,
        ST_READ,
        ST_DONE
    } secp_state_e;

    typedef enum logic [1:0] {
        KIND_WRITE,
        KIND_ERASE_ALL,
        KIND_WRITE_ALL
    } secp_kind_e;

    typedef struct packed {
        logic chip_select;
        logic serial_clock;
        logic serial_data_in;
    } secp_pins_s;

endpackage

// [hdl/secp_command_port.sv]
/*
 serial eeprom command port: start detect, opcode decode, read shifting,
 write enable state, self-timed program cycles and ready/busy.
 assumes the serial pins are already synchronous to ref_clk.
*/
// Operation
// - strap high gives 64x16, low 128x8
// - ready/busy low during self-timed cycles
// - program disabled after reset, enable needed
// - decode four opcode bits after start
// - address and data widths per organization, msb first
// - fixed clock edge count per instruction
// - start on first edge, select and data high
// - nothing happens before a start bit
// - execute after last bit, then ignore
// - read sends dummy zero then word
// - output released after last bit or deselect
// - read data goes out msb first
// - write erases then programs addressed location
// - write cycle 1 ms or 2 ms
// - erase-all sets every bit to one
// - erase-all finishes within 15 ms
// - write-all programs every location, 15 ms
// - bits sampled and launched on rising edges
// - deselect resets control, program cycle continues
`timescale 1ns/1ps

module secp_command_port #(
    parameter int WRITE8_CYCLES = secp_pkg::WRITE8_CYCLES,
    parameter int WRITE16_CYCLES = secp_pkg::WRITE16_CYCLES,
    parameter int ALL_CYCLES = secp_pkg::ALL_CYCLES
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire secp_pkg::secp_pins_s pins,
    input wire logic array_organization_strap,
    output logic serial_data_out,
    output logic serial_data_oe,
    output logic ready_busy_output
);

    ////////////////////////////////////////////////////////////////////////////
    // control state

    secp_pkg::secp_state_e state, next_state;
    secp_pkg::secp_kind_e kind, next_kind;
    secp_pkg::secp_timer_t timer, next_timer;
    logic [4:0] cnt, next_cnt;
    logic [15:0] shift, next_shift;
    logic [15:0] rd, next_rd;
    logic [15:0] wdata, next_wdata;
    logic [6:0] addr, next_addr;
    logic [3:0] opcode, next_opcode;
    logic wide, next_wide;
    logic prog_en, next_prog_en;
    logic busy, next_busy;
    logic dout, next_dout;
    logic doe, next_doe;
    logic sclk_q, next_sclk_q;
    logic [7:0] mem [secp_pkg::MEM_BYTES];

    logic sclk_rise;
    logic [15:0] rx;
    logic [4:0] k;
    logic [4:0] hdr;
    logic [4:0] dlen;
    logic [6:0] a;
    logic launch;
    secp_pkg::secp_kind_e launch_kind;
    logic finish;

    assign sclk_rise = pins.serial_clock && !sclk_q;
    assign finish = busy && (timer == '0);
    assign ready_busy_output = !busy;
    assign serial_data_out = dout;
    assign serial_data_oe = doe;

    always_comb begin
        next_state = state;
        next_kind = kind;
        next_timer = timer;
        next_cnt = cnt;
        next_shift = shift;
        next_rd = rd;
        next_wdata = wdata;
        next_addr = addr;
        next_opcode = opcode;
        next_wide = wide;
        next_prog_en = prog_en;
        next_busy = busy;
        next_dout = dout;
        next_doe = doe;
        next_sclk_q = pins.serial_clock;
        rx = {shift[14:0], pins.serial_data_in};
        k = cnt + 5'h01;
        hdr = wide ? secp_pkg::HDR16_BITS : secp_pkg::HDR8_BITS;
        dlen = wide ? secp_pkg::DATA16_BITS : secp_pkg::DATA8_BITS;
        a = wide ? {1'b0, rx[5:0]} : rx[6:0];
        launch = 1'b0;
        launch_kind = secp_pkg::KIND_WRITE;
        // the timed cycle ignores the select pin entirely
        if (busy) begin
            if (finish) begin
                next_busy = 1'b0;
            end else begin
                next_timer = timer - 20'h00001;
            end
        end
        if (!pins.chip_select) begin
            next_state = secp_pkg::ST_IDLE;
            next_doe = 1'b0;
            next_dout = 1'b0;
        end else if (sclk_rise) begin
            unique case (state)
                secp_pkg::ST_IDLE: begin
                    // starts are refused while a cycle runs, the line may be shared
                    if (pins.serial_data_in && !busy) begin
                        next_state = secp_pkg::ST_SHIFT;
                        next_cnt = '0;
                        next_wide = array_organization_strap;
                    end
                end
                secp_pkg::ST_SHIFT: begin
                    next_shift = rx;
                    next_cnt = k;
                    if (k == secp_pkg::OP_BITS) begin
                        next_opcode = rx[3:0];
                    end
                    if (k == hdr) begin
                        next_addr = a;
                        if (opcode[3:2] == secp_pkg::READ_PFX) begin
                            next_state = secp_pkg::ST_READ;
                            next_doe = 1'b1;
                            next_dout = 1'b0;
                            next_cnt = dlen;
                            if (wide) begin
                                next_rd = {mem[{a[5:0], 1'b1}], mem[{a[5:0], 1'b0}]};
                            end else begin
                                next_rd = {8'h00, mem[a]};
                            end
                        end else if (!opcode[2]) begin
                            next_state = secp_pkg::ST_DONE;
                            if (opcode == secp_pkg::OP_ENABLE) begin
                                next_prog_en = 1'b1;
                            end
                            if (opcode == secp_pkg::OP_DISABLE) begin
                                next_prog_en = 1'b0;
                            end
                            if (opcode == secp_pkg::OP_ERASE_ALL) begin
                                launch = 1'b1;
                                launch_kind = secp_pkg::KIND_ERASE_ALL;
                            end
                            if (opcode == secp_pkg::OP_WRITE_ALL) begin
                                next_state = secp_pkg::ST_SHIFT;
                            end
                        end
                    end
                    if (k == hdr + dlen) begin
                        next_wdata = wide ? rx : {8'h00, rx[7:0]};
                        next_state = secp_pkg::ST_DONE;
                        launch = 1'b1;
                        launch_kind = opcode[2] ? secp_pkg::KIND_WRITE
                                                : secp_pkg::KIND_WRITE_ALL;
                    end
                end
                secp_pkg::ST_READ: begin
                    if (cnt == '0) begin
                        next_doe = 1'b0;
                        next_dout = 1'b0;
                        next_state = secp_pkg::ST_DONE;
                    end else begin
                        next_dout = wide ? rd[15] : rd[7];
                        next_rd = {rd[14:0], 1'b0};
                        next_cnt = cnt - 5'h01;
                    end
                end
                secp_pkg::ST_DONE: begin
                    // only a deselect leaves here
                    next_state = secp_pkg::ST_DONE;
                end
            endcase
        end
        if (launch && prog_en) begin
            next_busy = 1'b1;
            next_kind = launch_kind;
            if (launch_kind != secp_pkg::KIND_WRITE) begin
                next_timer = secp_pkg::secp_timer_t'(ALL_CYCLES - 1);
            end else if (wide) begin
                next_timer = secp_pkg::secp_timer_t'(WRITE16_CYCLES - 1);
            end else begin
                next_timer = secp_pkg::secp_timer_t'(WRITE8_CYCLES - 1);
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state <= secp_pkg::ST_IDLE;
            kind <= secp_pkg::KIND_WRITE;
            timer <= '0;
            cnt <= '0;
            shift <= '0;
            rd <= '0;
            wdata <= '0;
            addr <= '0;
            opcode <= '0;
            wide <= 1'b1;
            prog_en <= 1'b0;
            busy <= 1'b0;
            dout <= 1'b0;
            doe <= 1'b0;
            sclk_q <= 1'b0;
        end else begin
            state <= next_state;
            kind <= next_kind;
            timer <= next_timer;
            cnt <= next_cnt;
            shift <= next_shift;
            rd <= next_rd;
            wdata <= next_wdata;
            addr <= next_addr;
            opcode <= next_opcode;
            wide <= next_wide;
            prog_en <= next_prog_en;
            busy <= next_busy;
            dout <= next_dout;
            doe <= next_doe;
            sclk_q <= next_sclk_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // array, updated when the timed cycle ends

    for (genvar i = 0; i < secp_pkg::MEM_BYTES; i++) begin : g_mem
        localparam logic [6:0] IDX = 7'(i);
        logic [7:0] next_byte;
        logic [7:0] pat;
        always_comb begin
            pat = (wide && IDX[0]) ? wdata[15:8] : wdata[7:0];
            next_byte = mem[i];
            if (finish) begin
                unique case (kind)
                    secp_pkg::KIND_WRITE: begin
                        if (wide ? (addr[5:0] == IDX[6:1]) : (addr == IDX)) begin
                            next_byte = pat;
                        end
                    end
                    secp_pkg::KIND_ERASE_ALL: next_byte = secp_pkg::ERASED_BYTE;
                    // programming only clears bits, there is no erase step here
                    secp_pkg::KIND_WRITE_ALL: next_byte = mem[i] & pat;
                endcase
            end
        end
        always_ff @(posedge ref_clk) begin
            if (reset) begin
                mem[i] <= secp_pkg::ERASED_BYTE;
            end else begin
                mem[i] <= next_byte;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    sequence s_start;
        state == secp_pkg::ST_IDLE && pins.chip_select && pins.serial_data_in
            && sclk_rise && !busy;
    endsequence

    sequence s_read_hdr_end;
        state == secp_pkg::ST_SHIFT && pins.chip_select && sclk_rise && k == hdr
            && opcode[3:2] == secp_pkg::READ_PFX;
    endsequence

    sequence s_dummy_out;
        doe && !dout && state == secp_pkg::ST_READ;
    endsequence

    strap_capture_a: assert property (s_start |=> wide == $past(array_organization_strap))
        else $error("organization not taken from strap at start");
    busy_ready_a: assert property (busy && timer != '0 |=> !ready_busy_output)
        else $error("ready shown during a running cycle");
    enable_gate_a: assert property ($rose(busy) |-> $past(prog_en))
        else $error("program cycle started while disabled");
    start_detect_a: assert property (s_start |=> state == secp_pkg::ST_SHIFT && cnt == '0)
        else $error("start bit not taken");
    idle_quiet_a: assert property (state == secp_pkg::ST_IDLE && !pins.serial_data_in
        |=> state == secp_pkg::ST_IDLE && $stable(prog_en) && !doe)
        else $error("activity before start bit");
    dummy_zero_a: assert property (s_read_hdr_end |=> s_dummy_out)
        else $error("dummy zero missing");
    deselect_release_a: assert property (!pins.chip_select
        |=> !serial_data_oe && state == secp_pkg::ST_IDLE)
        else $error("output or control not reset on deselect");
    cycle_survives_a: assert property (busy && timer != '0 && !pins.chip_select |=> busy)
        else $error("deselect aborted program cycle");
    done_ignore_a: assert property (state == secp_pkg::ST_DONE && pins.chip_select
        |=> state == secp_pkg::ST_DONE && $stable(opcode))
        else $error("input taken after instruction end");
    write_time_a: assert property ($rose(busy) && kind == secp_pkg::KIND_WRITE && wide
        |-> timer == secp_pkg::secp_timer_t'(WRITE16_CYCLES - 1))
        else $error("16-bit write cycle length wrong");

endmodule // secp_command_port

// [tb/secp_master_model.sv]
/*
 master model: drives select, serial clock and data in, one frame of n bits per call.
 assumes the port samples its pins on ref_clk and answers on data out and its enable.
*/
`timescale 1ns/1ps

module secp_master_model (
    input wire logic ref_clk,
    input wire logic serial_data_out,
    input wire logic serial_data_oe,
    output secp_pkg::secp_pins_s pins
);
    logic [26:0] cap;
    logic [26:0] cap_oe;
    logic fin_oe;

    initial pins = '0;

    ////////////////////////////////////////////////////////////////////////////////
    // data moves only while the clock is low, each phase two ref_clk long
    task automatic rise(input logic d);
        pins.serial_clock <= 1'b0;
        pins.serial_data_in <= d;
        repeat (2) @(posedge ref_clk);
        pins.serial_clock <= 1'b1;
        repeat (2) @(posedge ref_clk);
    endtask

    // v goes out from bit 26 down; n rises counting the start bit
    task automatic frame(input logic [26:0] v, input int n, input int lead);
        cap = '0;
        cap_oe = '0;
        pins.chip_select <= 1'b1;
        repeat (2) @(posedge ref_clk);
        repeat (lead) rise(1'b0);
        for (int k = 0; k < n; k++) begin
            rise(v[26 - k]);
            cap[26 - k] = serial_data_out;
            cap_oe[26 - k] = serial_data_oe;
        end
        rise(~v[27 - n]);
        fin_oe = serial_data_oe;
        // released line flips, so a stale level never passes for data
        pins.chip_select <= 1'b0;
        pins.serial_clock <= 1'b0;
        pins.serial_data_in <= v[27 - n];
        repeat (2) @(posedge ref_clk);
    endtask
endmodule // secp_master_model

// [tb/serial_eeprom_command_port_tb.sv]
/*
 bench for the serial eeprom command port: a table of frames, then hand cases.
 assumes shortened self-timed cycles and the master model on the serial pins.
*/
`timescale 1ns/1ps

module serial_eeprom_command_port_tb;
    typedef struct packed {
        logic wide;
        logic [3:0] op;
        logic [6:0] addr;
        logic [15:0] data;
        logic [7:0] busy;
        logic [15:0] rd;
    } secp_row_s;

    localparam int W8 = 20;
    localparam int W16 = 40;
    localparam int AL = 60;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic array_organization_strap = 1'b1;
    secp_pkg::secp_pins_s pins;
    logic serial_data_out;
    logic serial_data_oe;
    logic ready_busy_output;
    int fail_count = 0;
    int check_count = 0;
    int busy_cnt = 0;
    int busy_mark = 0;
    // enable precedes every write but rows 1 and 15, erase-all precedes write-all
    secp_row_s rows [17] = '{
        '{1'b1, 4'hB, 7'h05, 16'h0000, 8'h00, 16'hFFFF},
        '{1'b1, 4'h4, 7'h05, 16'hA5C3, 8'h00, 16'h0000},
        '{1'b1, 4'h3, 7'h00, 16'h0000, 8'h00, 16'h0000},
        '{1'b1, 4'hC, 7'h05, 16'hA5C3, 8'h28, 16'h0000},
        '{1'b1, 4'h8, 7'h05, 16'h0000, 8'h00, 16'hA5C3},
        '{1'b0, 4'h8, 7'h0A, 16'h0000, 8'h00, 16'h00C3},
        '{1'b0, 4'h9, 7'h0B, 16'h0000, 8'h00, 16'h00A5},
        '{1'b0, 4'h7, 7'h7F, 16'h005A, 8'h14, 16'h0000},
        '{1'b0, 4'hA, 7'h7F, 16'h0000, 8'h00, 16'h005A},
        '{1'b1, 4'h2, 7'h00, 16'h0000, 8'h3C, 16'h0000},
        '{1'b1, 4'h8, 7'h05, 16'h0000, 8'h00, 16'hFFFF},
        '{1'b1, 4'h1, 7'h00, 16'h1234, 8'h3C, 16'h0000},
        '{1'b0, 4'h8, 7'h00, 16'h0000, 8'h00, 16'h0034},
        '{1'b1, 4'h8, 7'h3F, 16'h0000, 8'h00, 16'h1234},
        '{1'b1, 4'h0, 7'h00, 16'h0000, 8'h00, 16'h0000},
        '{1'b1, 4'h5, 7'h01, 16'h0000, 8'h00, 16'h0000},
        '{1'b1, 4'h8, 7'h01, 16'h0000, 8'h00, 16'h1234}
    };

    always #12.5 ref_clk = ~ref_clk;
    // free-running count of busy cycles; scenarios take differences of it
    always @(posedge ref_clk) begin
        if (ready_busy_output === 1'b0) begin
            busy_cnt <= busy_cnt + 1;
        end
    end

    secp_command_port #(.WRITE8_CYCLES(W8), .WRITE16_CYCLES(W16), .ALL_CYCLES(AL)) uut (
        .ref_clk(ref_clk), .reset(reset), .pins(pins),
        .array_organization_strap(array_organization_strap),
        .serial_data_out(serial_data_out), .serial_data_oe(serial_data_oe),
        .ready_busy_output(ready_busy_output)
    );

    secp_master_model master (
        .ref_clk(ref_clk), .serial_data_out(serial_data_out),
        .serial_data_oe(serial_data_oe), .pins(pins)
    );

    ////////////////////////////////////////////////////////////////////////////////
    task automatic results();
        if (fail_count == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic ok, input string msg);
        check_count++;
        if (ok !== 1'b1) begin
            fail_count++;
            $display("ERROR %0t %s", $time, msg);
        end
    endtask

    task automatic wait_ready();
        for (int i = 0; i < 200 && ready_busy_output !== 1'b1; i++) @(posedge ref_clk);
        @(posedge ref_clk);
        chk(ready_busy_output === 1'b1, "ready not back");
    endtask

    task automatic run_row(input secp_row_s r, input int lead);
        logic [26:0] v;
        logic [15:0] word;
        logic lng;
        int n;
        int l;
        int b;
        int seen;
        lng = (r.op[3:2] == 2'b10) || r.op[2] || (r.op == 4'h1);
        l = r.wide ? 10 : 11;
        n = r.wide ? (lng ? 27 : 11) : (lng ? 20 : 12);
        b = r.busy;
        v = r.wide ? {1'b1, r.op, r.addr[5:0], r.data} : {1'b1, r.op, r.addr, r.data[7:0], 7'h00};
        array_organization_strap <= r.wide;
        busy_mark = busy_cnt;
        master.frame(v, n, lead);
        if (r.op[3:2] == 2'b10) begin
            word = r.wide ? master.cap[15:0] : {8'h00, master.cap[14:7]};
            chk(master.cap[26 - l] === 1'b0, "dummy bit");
            chk(word === r.rd, "read word");
            chk(master.cap_oe[26 - l] === 1'b1 && master.cap_oe[27 - n] === 1'b1, "no drive");
            chk(master.fin_oe === 1'b0, "drive after last bit");
        end else begin
            chk(master.cap_oe === 27'h0000000, "drive outside read");
        end
        wait_ready();
        seen = busy_cnt - busy_mark;
        chk((b == 0) ? seen == 0 : (seen >= b - 1 && seen <= b + 2), "busy");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        chk(ready_busy_output === 1'b1 && serial_data_oe === 1'b0, "reset state");
        foreach (rows[i]) run_row(rows[i], 0);
        run_row(rows[13], 3);
        run_row(rows[2], 0);
        busy_mark = busy_cnt;
        master.frame({1'b1, 4'h4, 6'h01, 16'h0000}, 20, 0);
        wait_ready();
        chk(busy_cnt == busy_mark, "short frame executed");
        run_row(rows[16], 0);
        // cut a read short: deselect must release data out
        master.frame({1'b1, 4'h8, 6'h05, 16'h0000}, 14, 0);
        chk(master.cap_oe[13] === 1'b1, "no drive mid read");
        chk(serial_data_oe === 1'b0, "drive after deselect");
        // reset in mid-run while enabled: enable must drop and the array refill with ones
        reset <= 1'b1;
        repeat (2) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        chk(ready_busy_output === 1'b1 && serial_data_oe === 1'b0, "mid-run reset");
        run_row(rows[1], 0);
        run_row(rows[0], 0);
        results();
    end

    initial begin
        repeat (20000) @(posedge ref_clk);
        fail_count++;
        results();
    end
endmodule // serial_eeprom_command_port_tb
